/* File: rtl/cmc_pkg.sv */
// Purpose: Constants and types for the computation mode configuration register.
// Assumes: One 16-bit register on the host register port, main clock domain only.
// Notes: The register sits at its printed offset on the host register port.
// Overview of operation
// RL1: Bits 2:0 pick phases A, B, C summed into pulse output one, all set after reset.
// RL2: Bits 5:3 pick phases A, B, C summed into pulse output two, all set after reset.
// RL3: Bits 8:6 pick phases A, B, C summed into pulse output three, all set after reset.
// RL4: Bits 10:9 pick the angle measurement: V-to-I, V-to-V, I-to-I or none, 00 after reset.
// RL5: Bit 11 set makes phase A use the nominal voltage value instead of its measured rms voltage.
// RL6: Bit 12 set makes phase B use the nominal voltage value instead of its measured rms voltage.
// RL7: Bit 13 set makes phase C use the nominal voltage value instead of its measured rms voltage.
// RL8: Software leaves bit 14 at 0 for 50 Hz mains and sets it for 60 Hz mains.
// RL9: Bit 15 is reserved, reads 0 and steers nothing.
// RL10: Each pulse output follows the sum of the power over only its selected phases.
// RL11: A deselected phase adds nothing, and a change applies from the next computation cycle.
package cmc_pkg;
  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 16;
  localparam logic [ADDR_W-1:0] COMPUTATION_MODE_CONFIG_ADDR = 16'hE60E;
  localparam logic [REG_W-1:0] COMPUTATION_MODE_CONFIG_RESET = 16'h01FF;
  localparam logic [REG_W-1:0] COMPUTATION_MODE_CONFIG_WMASK = 16'h7FFF;
  localparam int unsigned PULSE1_SEL_LSB = 0;
  localparam int unsigned PULSE2_SEL_LSB = 3;
  localparam int unsigned PULSE3_SEL_LSB = 6;
  localparam int unsigned ANGLE_SEL_LSB = 9;
  localparam int unsigned NOMINAL_EN_LSB = 11;
  localparam int unsigned LINE_FREQ_BIT = 14;
  localparam int unsigned RESERVED_BIT = 15;
  localparam int unsigned NUM_PHASES = 3;
  localparam int unsigned NUM_PULSE_OUTPUTS = 3;

  typedef enum logic [1:0] {
    CMC_ANGLE_VOLT_CURRENT = 2'b00,
    CMC_ANGLE_VOLT_VOLT = 2'b01,
    CMC_ANGLE_CURRENT_CURRENT = 2'b10,
    CMC_ANGLE_NONE = 2'b11
  } cmc_angle_e;

  typedef struct packed {
    logic reserved;
    logic line_frequency_select;
    logic [2:0] nominal_volt_enable;
    cmc_angle_e angle_measure_select;
    logic [2:0] pulse3_phase_select;
    logic [2:0] pulse2_phase_select;
    logic [2:0] pulse1_phase_select;
  } cmc_mode_s;

  typedef struct packed {
    logic volt_current;
    logic volt_volt;
    logic current_current;
  } cmc_angle_s;
endpackage

/* File: rtl/cmc_phase_sum.sv */
// Purpose: Sums the power of the selected phases for one pulse output.
// Assumes: Phase powers and the strobe come from logic on the same clock.
// Notes: The sum is taken only on the computation strobe.
`timescale 1ns/1ns
module cmc_phase_sum #(
  parameter int unsigned POWER_W = 24
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic compute_i,
  input wire logic [cmc_pkg::NUM_PHASES-1:0] phase_select_i,
  input wire logic signed [cmc_pkg::NUM_PHASES-1:0][POWER_W-1:0] phase_power_i,
  output logic signed [POWER_W+1:0] sum_o
);
  import cmc_pkg::*;

  logic signed [POWER_W+1:0] next_sum;

  // A deselected phase is skipped by the select test, so it adds nothing to the sum.
  always_comb begin
    next_sum = sum_o;
    if (compute_i) begin
      next_sum = '0;
      // One element of a signed packed array reads as unsigned, so it is re-signed before widening.
      for (int i = 0; i < NUM_PHASES; i++) begin
        if (phase_select_i[i]) begin // RL11
          next_sum = next_sum + (POWER_W+2)'($signed(phase_power_i[i])); // RL10
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sum_o <= '0;
    end else if (ce_i) begin
      sum_o <= next_sum;
    end
  end
endmodule // cmc_phase_sum

/* File: rtl/cmc_top.sv */
// Purpose: Computation mode configuration register and the settings it steers.
// Assumes: Host register port and computation strobe are on clk_i.
// Notes: A write lands at once; sums pick it up on the next computation strobe.
//   The line frequency bit is only carried out; nothing here acts on it.
//   Angle flags stay low for one cycle after reset, until the default decode is registered.
//   Phase powers are summed two bits wider, so three full-scale terms cannot wrap.
//   The clock enable freezes every register, the read port included.
`timescale 1ns/1ns
module cmc_top #(
  parameter int unsigned POWER_W = 24,
  parameter int unsigned VRMS_W = 24
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [cmc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [cmc_pkg::REG_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [cmc_pkg::REG_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic compute_i,
  input wire logic signed [cmc_pkg::NUM_PHASES-1:0][POWER_W-1:0] phase_power_i,
  input wire logic [cmc_pkg::NUM_PHASES-1:0][VRMS_W-1:0] phase_vrms_i,
  input wire logic [VRMS_W-1:0] nominal_voltage_value_i,
  output logic [cmc_pkg::NUM_PHASES-1:0][VRMS_W-1:0] apparent_vrms_o,
  output logic signed [cmc_pkg::NUM_PULSE_OUTPUTS-1:0][POWER_W+1:0] pulse_sum_o,
  output cmc_pkg::cmc_mode_s mode_o,
  output cmc_pkg::cmc_angle_s angle_measure_o,
  output logic line_frequency_select_o
);
  import cmc_pkg::*;

  // Register state and the raw word view of it.
  cmc_mode_s mode;
  cmc_mode_s next_mode;
  logic [REG_W-1:0] mode_word;
  logic write_hit;
  logic [REG_W-1:0] write_value;

  // Read port.
  logic read_hit;
  logic [REG_W-1:0] next_rdata;
  logic next_rvalid;

  // Registered copies and decoded settings.
  cmc_mode_s next_mode_copy;
  logic next_line_freq;
  cmc_angle_s next_angle;
  logic [NUM_PHASES-1:0] nominal_enable;
  logic [NUM_PHASES-1:0][VRMS_W-1:0] next_vrms;
  logic [NUM_PULSE_OUTPUTS-1:0][NUM_PHASES-1:0] pulse_select;

  // Address decode, shared by the write path and the read path.
  function automatic logic hit(
    input logic [ADDR_W-1:0] addr
  );
    hit = (addr == COMPUTATION_MODE_CONFIG_ADDR);
  endfunction

  // Low bit of the phase select field that feeds one pulse output.
  function automatic int unsigned select_lsb(
    input int unsigned output_index
  );
    case (output_index)
      0: select_lsb = PULSE1_SEL_LSB;
      1: select_lsb = PULSE2_SEL_LSB;
      2: select_lsb = PULSE3_SEL_LSB;
      default: select_lsb = PULSE1_SEL_LSB;
    endcase
  endfunction

  // A three-bit field cut from the register word, one bit per phase.
  function automatic logic [NUM_PHASES-1:0] phase_field(
    input logic [REG_W-1:0] word,
    input int unsigned lsb
  );
    phase_field = word[lsb +: NUM_PHASES];
  endfunction

  // Code 11 leaves every flag low, so no angle measurement runs.
  function automatic cmc_angle_s decode_angle(
    input cmc_angle_e code
  );
    cmc_angle_s flags;
    flags = '0;
    case (code)
      CMC_ANGLE_VOLT_CURRENT: begin
        flags.volt_current = 1'b1; // RL4
      end
      CMC_ANGLE_VOLT_VOLT: begin
        flags.volt_volt = 1'b1; // RL4
      end
      CMC_ANGLE_CURRENT_CURRENT: begin
        flags.current_current = 1'b1; // RL4
      end
      CMC_ANGLE_NONE: begin
        flags = '0; // RL4
      end
      default: begin
        flags = '0;
      end
    endcase
    decode_angle = flags;
  endfunction

  // The measured value is dropped entirely when the nominal value is enabled.
  function automatic logic [VRMS_W-1:0] pick_vrms(
    input logic use_nominal,
    input logic [VRMS_W-1:0] nominal,
    input logic [VRMS_W-1:0] measured
  );
    if (use_nominal) begin
      pick_vrms = nominal;
    end else begin
      pick_vrms = measured;
    end
  endfunction

  assign mode_word = REG_W'(mode);

  // Bit 15 is masked on write so it stays 0 and steers nothing.
  always_comb begin
    write_hit = reg_write_i && hit(reg_addr_i);
    write_value = reg_wdata_i & COMPUTATION_MODE_CONFIG_WMASK; // RL9
    next_mode = mode;
    if (write_hit) begin
      next_mode = cmc_mode_s'(write_value);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode <= cmc_mode_s'(COMPUTATION_MODE_CONFIG_RESET); // RL1 RL2 RL3 RL4 RL5 RL6 RL7 RL9
    end else if (ce_i) begin
      mode <= next_mode;
    end
  end

  // The read word is taken before the edge, so a read beside a write returns the old value.
  // Any other address reads as zero with the valid pulse, which lets a host probe safely.
  always_comb begin
    read_hit = reg_read_i && hit(reg_addr_i);
    next_rvalid = reg_read_i;
    next_rdata = reg_rdata_o;
    if (read_hit) begin
      next_rdata = mode_word;
    end else if (reg_read_i) begin
      next_rdata = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rdata_o <= next_rdata;
      reg_rvalid_o <= next_rvalid;
    end
  end

  // Decoded settings are registered so that every output leaves a flip-flop.
  always_comb begin
    next_mode_copy = mode;
    next_line_freq = mode_word[LINE_FREQ_BIT]; // RL8
    next_angle = decode_angle(mode.angle_measure_select); // RL4
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_o <= cmc_mode_s'(COMPUTATION_MODE_CONFIG_RESET);
      line_frequency_select_o <= 1'b0;
      angle_measure_o <= '0;
    end else if (ce_i) begin
      mode_o <= next_mode_copy;
      line_frequency_select_o <= next_line_freq;
      angle_measure_o <= next_angle;
    end
  end

  assign nominal_enable = phase_field(mode_word, NOMINAL_EN_LSB);

  generate
    for (genvar p = 0; p < NUM_PHASES; p++) begin : g_vsel
      assign next_vrms[p] = pick_vrms(nominal_enable[p], nominal_voltage_value_i,
                                      phase_vrms_i[p]); // RL5 RL6 RL7
    end
  endgenerate

  // Apparent voltages track the inputs one clock late on every enabled cycle, strobe or not.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      apparent_vrms_o <= '0;
    end else if (ce_i) begin
      apparent_vrms_o <= next_vrms;
    end
  end

  // Selects come from the live register, so a write reaches the first strobe after its edge.
  generate
    for (genvar k = 0; k < NUM_PULSE_OUTPUTS; k++) begin : g_select
      assign pulse_select[k] = phase_field(mode_word, select_lsb(k)); // RL1 RL2 RL3 RL11
    end
  endgenerate

  // Each pulse output has its own adder, so one output's selection never disturbs another.
  generate
    for (genvar k = 0; k < NUM_PULSE_OUTPUTS; k++) begin : g_sum
      cmc_phase_sum #(
        .POWER_W(POWER_W)
      ) u_sum (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .compute_i(compute_i),
        .phase_select_i(pulse_select[k]), // RL10 RL11
        .phase_power_i(phase_power_i),
        .sum_o(pulse_sum_o[k])
      );
    end
  endgenerate
endmodule // cmc_top

/* File: bench/cmc_top_properties.sv */
// Purpose: Port assertions for the computation mode register.
// Assumes: Bound into cmc_top, one clock domain.
// Notes: Outputs are judged against mode_o, which holds the value they were built from.
`timescale 1ns/1ns
module cmc_top_properties import cmc_pkg::*; #(
  parameter int unsigned POWER_W = 24,
  parameter int unsigned VRMS_W = 24
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [REG_W-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic compute_i,
  input wire logic signed [NUM_PHASES-1:0][POWER_W-1:0] phase_power_i,
  input wire logic [NUM_PHASES-1:0][VRMS_W-1:0] phase_vrms_i,
  input wire logic [VRMS_W-1:0] nominal_voltage_value_i,
  input wire logic [NUM_PHASES-1:0][VRMS_W-1:0] apparent_vrms_o,
  input wire logic signed [NUM_PULSE_OUTPUTS-1:0][POWER_W+1:0] pulse_sum_o,
  input wire cmc_mode_s mode_o,
  input wire cmc_angle_s angle_measure_o,
  input wire logic line_frequency_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Wide signed sum, so a carry out of the phase width cannot hide a slip.
  function automatic logic signed [31:0] psum(input logic [2:0] s,
                                              input logic [2:0][POWER_W-1:0] p);
    psum = 0;
    for (int i = 0; i < 3; i++) begin
      if (s[i]) psum += $signed(p[i]);
    end
  endfunction
  a_sum_one_sel: assert property (ce_i && compute_i |=>
    $signed(pulse_sum_o[0]) == psum(mode_o.pulse1_phase_select, $past(phase_power_i)))
    else $error("Pulse one sum wrong");
  a_sum_two_sel: assert property (ce_i && compute_i |=>
    $signed(pulse_sum_o[1]) == psum(mode_o.pulse2_phase_select, $past(phase_power_i)))
    else $error("Pulse two sum wrong");
  a_sum_three_sel: assert property (ce_i && compute_i |=>
    $signed(pulse_sum_o[2]) == psum(mode_o.pulse3_phase_select, $past(phase_power_i)))
    else $error("Pulse three sum wrong");
  a_angle_decode: assert property (!$past(reset_i) |-> angle_measure_o ==
    {mode_o.angle_measure_select == 2'h0, mode_o.angle_measure_select == 2'h1,
     mode_o.angle_measure_select == 2'h2}) else $error("Angle flags wrong");
  a_nom_phase_a: assert property (ce_i |=> apparent_vrms_o[0] ==
    (mode_o.nominal_volt_enable[0] ? $past(nominal_voltage_value_i) : $past(phase_vrms_i[0])))
    else $error("Phase A voltage wrong");
  a_nom_phase_b: assert property (ce_i |=> apparent_vrms_o[1] ==
    (mode_o.nominal_volt_enable[1] ? $past(nominal_voltage_value_i) : $past(phase_vrms_i[1])))
    else $error("Phase B voltage wrong");
  a_nom_phase_c: assert property (ce_i |=> apparent_vrms_o[2] ==
    (mode_o.nominal_volt_enable[2] ? $past(nominal_voltage_value_i) : $past(phase_vrms_i[2])))
    else $error("Phase C voltage wrong");
  a_line_freq: assert property (line_frequency_select_o == mode_o.line_frequency_select)
    else $error("Line frequency flag wrong");
  a_reserved_zero: assert property (reg_rvalid_o |-> !reg_rdata_o[15] && !mode_o.reserved)
    else $error("Reserved bit set");
  c_compute: cover property (ce_i && compute_i && mode_o.pulse2_phase_select == 3'h6);
  c_read: cover property (reg_rvalid_o);
  c_angle: cover property (angle_measure_o.volt_volt);
  c_nominal_b: cover property (mode_o.nominal_volt_enable[1]);
endmodule // cmc_top_properties
bind cmc_top cmc_top_properties #(.POWER_W(POWER_W), .VRMS_W(VRMS_W)) u_props (.*);

/* File: bench/computation_mode_config_tb_top.sv */
// Purpose: Self-checking bench for the computation mode register.
// Assumes: Inputs change on the falling clock edge.
// Notes: Expected sums are worked out by hand from fixed phase powers.
`timescale 1ns/1ns
module computation_mode_config_tb_top;
  import cmc_pkg::*;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
  logic clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, compute_i = 1'b0;
  logic reg_write_i = 1'b0, reg_read_i = 1'b0, reg_rvalid_o, line_frequency_select_o;
  logic [15:0] reg_addr_i = 16'h0000, reg_wdata_i = 16'h0000, reg_rdata_o;
  logic [2:0][23:0] phase_power_i = {24'h000005, 24'hFFFFE2, 24'h000064};
  logic [2:0][23:0] phase_vrms_i = {24'h000003, 24'h000002, 24'h000001};
  logic [23:0] nominal_voltage_value_i = 24'h000007;
  logic [2:0][23:0] apparent_vrms_o;
  logic [2:0][25:0] pulse_sum_o;
  cmc_mode_s mode_o;
  cmc_angle_s angle_measure_o;
  int num_errors = 0, checks_done = 0;
  cmc_top dut (.*);
  initial forever #10 clk_i = ~clk_i;
  task automatic end_sim();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_write_i = 1'b1;
    @(negedge clk_i);
    reg_write_i = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_read_i = 1'b1;
    @(negedge clk_i);
    reg_read_i = 1'b0;
    for (int i = 0; i < 4 && reg_rvalid_o !== 1'b1; i++) @(negedge clk_i);
    `CHK(reg_rvalid_o, 1'b1)
    if (reg_rvalid_o !== 1'b1) end_sim();
    `CHK(reg_rdata_o, e)
  endtask
  task automatic cmp(input logic [25:0] e0, input logic [25:0] e1, input logic [25:0] e2);
    @(negedge clk_i);
    compute_i = 1'b1;
    @(negedge clk_i);
    compute_i = 1'b0;
    `CHK(pulse_sum_o, {e2, e1, e0})
  endtask
  task automatic t_defaults();
    rd(16'hE60E, 16'h01FF);
    cmp(26'h000004B, 26'h000004B, 26'h000004B);
  endtask
  task automatic t_select();
    wr(16'hE60E, 16'hEE31);
    cmp(26'h0000064, 26'h3FFFFE7, 26'h0000000);
    rd(16'hE60E, 16'h6E31);
    `CHK(line_frequency_select_o, 1'b1)
    `CHK(angle_measure_o, 3'h0)
    `CHK(mode_o, 16'h6E31)
    `CHK(apparent_vrms_o, {24'h000007, 24'h000002, 24'h000007})
  endtask
  task automatic t_angle();
    for (int c = 0; c < 3; c++) begin
      wr(16'hE60E, 16'(c << 9));
      @(negedge clk_i);
      `CHK(angle_measure_o, 3'h4 >> c)
    end
  endtask
  // A write with the clock enable low or to a neighbour address must not land.
  task automatic t_refused();
    @(negedge clk_i);
    ce_i = 1'b0;
    wr(16'hE60E, 16'h0000);
    ce_i = 1'b1;
    wr(16'hE60F, 16'h0000);
    rd(16'hE60E, 16'h0400);
    rd(16'hE60F, 16'h0000);
  endtask
  // Only phase B takes the nominal value; no phase feeds any pulse output.
  task automatic t_nominal_b();
    wr(16'hE60E, 16'h1000);
    @(negedge clk_i);
    `CHK(apparent_vrms_o, {24'h000003, 24'h000007, 24'h000001})
    `CHK(line_frequency_select_o, 1'b0)
    `CHK(mode_o, 16'h1000)
    cmp(26'h0000000, 26'h0000000, 26'h0000000);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    t_defaults();
    t_select();
    t_angle();
    t_refused();
    t_nominal_b();
    end_sim();
  end
endmodule // computation_mode_config_tb_top
